// File: serializer_link_regs.svh
`ifndef SERIALIZER_LINK_REGS_SVH
`define SERIALIZER_LINK_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define REG_REMOTE_SLAVE0_TARGET_ADDR 8'h07
`define REG_REMOTE_SLAVE0_ALIAS_ADDR  8'h08
`define REG_BACKCHANNEL_CRC_COUNT_LOW 8'h0a
`define REG_BACKCHANNEL_CRC_COUNT_HIGH 8'h0b
`define REG_GENERAL_LINK_STATUS       8'h0c
`define REG_PIN_ZERO_CONFIG_AND_REV   8'h0d

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ADDR_FIELD_MSB        7
`define ADDR_FIELD_LSB        1
`define STAT_LINK_LOST_BIT    4
`define STAT_SELFTEST_ERR_BIT 3
`define STAT_CLOCK_BIT        2
`define STAT_NORMAL_ERR_BIT   1
`define STAT_LINK_UP_BIT      0
`define PIN_REV_MSB           7
`define PIN_REV_LSB           4
`define PIN_OUT_VALUE_BIT     3
`define PIN_MODE_MSB          2
`define PIN_MODE_LSB          0

// ------------------------------------------------------------
// Reset values and mode codes
// ------------------------------------------------------------
`define RST_ADDR_FIELD        7'h00
`define RST_CRC_COUNT         16'h0000
`define RST_PIN_MODE          3'h0
`define RST_PIN_OUT_VALUE     1'b0
`define RST_RDATA             8'h00
`define PIN_MODE_LOCAL_OUT    3'h1
`define PIN_MODE_LOCAL_IN     3'h3
`define PIN_MODE_REMOTE_HOLD  3'h5
`define PIN_MODE_REMOTE_DFLT  3'h7
`define PIN_MODE_TRISTATE_LO  2'h2

`endif

// File: serializer_link_pkg.sv
package serializer_link_pkg;

  // Per-port events from the back-channel receiver
  typedef struct packed {
    logic crc_err;
    logic selftest_active;
    logic selftest_restart;
  } port_events_t;

  // Per-port flags as seen in the status register
  typedef struct packed {
    logic link_lost;
    logic selftest_err;
    logic normal_err;
  } port_flags_t;

  // Request to forward a local I2C transaction to a remote slave
  typedef struct packed {
    logic       valid;
    logic       port;
    logic [6:0] alias_addr;
  } fwd_req_t;

  // Result of the alias lookup
  typedef struct packed {
    logic       done;
    logic       hit;
    logic       port;
    logic [6:0] target_addr;
  } fwd_rsp_t;

endpackage

// File: port_error_tracker.sv
`include "serializer_link_regs.svh"

module port_error_tracker #(
  parameter int CNT_W = 16
) (
  input  wire logic                        clock_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        ce_i,
  input  wire serializer_link_pkg::port_events_t events_i,
  input  wire logic                        link_up_i,
  input  wire logic                        err_reset_i,
  output logic [CNT_W-1:0]                 count_o,
  output serializer_link_pkg::port_flags_t flags_o
);
  import serializer_link_pkg::*;

  logic             link_up_prev_r;
  logic [CNT_W-1:0] count_r;
  port_flags_t      flags_r;

  wire link_loss_evt   = link_up_prev_r & ~link_up_i;
  wire selftest_crc    = events_i.crc_err & events_i.selftest_active;
  wire normal_crc      = events_i.crc_err & ~events_i.selftest_active;
  wire count_full      = &count_r;
  wire [CNT_W-1:0] count_inc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};

  // ------------------------------------------------------------
  // Error counter
  // ------------------------------------------------------------
  // counter clears
  // count each error
  // Saturates rather than wraps so a flood never looks like a few errors
  wire [CNT_W-1:0] count_nxt =
    err_reset_i ? (events_i.crc_err ? {{(CNT_W-1){1'b0}}, 1'b1} : '0) :
    (events_i.crc_err && !count_full) ? count_inc : count_r;

  // ------------------------------------------------------------
  // Sticky flags; a set in the clearing cycle wins
  // ------------------------------------------------------------
  // sticky link lost
  wire lost_nxt = link_loss_evt | (flags_r.link_lost & ~err_reset_i);
  wire st_clr   = err_reset_i | link_loss_evt | events_i.selftest_restart;
  wire st_nxt   = selftest_crc | (flags_r.selftest_err & ~st_clr);
  wire ne_nxt   = normal_crc | (flags_r.normal_err & ~(err_reset_i | link_loss_evt));

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_up_prev_r <= 1'b0;
      count_r        <= '0;
      flags_r        <= '0;
    end else if (ce_i) begin
      link_up_prev_r <= link_up_i;
      count_r        <= count_nxt;
      flags_r        <= '{link_lost: lost_nxt, selftest_err: st_nxt, normal_err: ne_nxt};
    end
  end

  assign count_o = count_r;
  assign flags_o = flags_r;

endmodule

// File: serializer_link_status_gpio_regs.sv
`include "serializer_link_regs.svh"

module serializer_link_status_gpio_regs #(
  parameter int         PORTS    = 2,
  parameter logic [3:0] REVISION = 4'h0  // Arbitrary value
) (
  input  wire logic                               clock_i,
  input  wire logic                               reset_n_i,
  input  wire logic                               ce_i,
  input  wire logic [7:0]                         reg_addr_i,
  input  wire logic                               reg_wr_i,
  input  wire logic                               reg_rd_i,
  input  wire logic [7:0]                         reg_wdata_i,
  output logic [7:0]                              reg_rdata_o,
  input  wire logic                               second_port_view_select_i,
  input  wire logic                               err_reset_i,
  input  wire serializer_link_pkg::port_events_t [1:0] port_events_i,
  input  wire logic [1:0]                         link_detect_i,
  input  wire logic                               input_clock_present_i,
  input  wire logic [1:0]                         remote_pin_value_i,
  input  wire serializer_link_pkg::fwd_req_t      fwd_req_i,
  output serializer_link_pkg::fwd_rsp_t           fwd_rsp_o,
  input  wire logic                               pin_zero_in_i,
  output logic                                    pin_zero_o,
  output logic                                    pin_zero_oe_o,
  input  wire logic                               second_port_pin_zero_in_i,
  output logic                                    second_port_pin_zero_o,
  output logic                                    second_port_pin_zero_oe_o,
  output logic [1:0]                              local_pin_value_o
);
  import serializer_link_pkg::*;

  // ------------------------------------------------------------
  // Synchronisers for pins and foreign-domain levels
  // ------------------------------------------------------------
  // Only the second stage is ever read, to keep metastability contained
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  wire  [4:0] async_in = {second_port_pin_zero_in_i, pin_zero_in_i,
                          input_clock_present_i, link_detect_i};

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (ce_i) begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  wire [1:0] link_up       = sync2_r[1:0];
  wire       clock_present = sync2_r[2];
  wire [1:0] pin_in        = sync2_r[4:3];

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // port steering
  wire       sel      = second_port_view_select_i;
  wire       hit_tgt  = reg_addr_i == `REG_REMOTE_SLAVE0_TARGET_ADDR;
  wire       hit_als  = reg_addr_i == `REG_REMOTE_SLAVE0_ALIAS_ADDR;
  wire       hit_cntl = reg_addr_i == `REG_BACKCHANNEL_CRC_COUNT_LOW;
  wire       hit_cnth = reg_addr_i == `REG_BACKCHANNEL_CRC_COUNT_HIGH;
  wire       hit_stat = reg_addr_i == `REG_GENERAL_LINK_STATUS;
  wire       hit_pin  = reg_addr_i == `REG_PIN_ZERO_CONFIG_AND_REV;
  wire [1:0] port_we  = sel ? 2'b10 : 2'b01;

  // ------------------------------------------------------------
  // Per-port configuration and status
  // ------------------------------------------------------------
  logic [6:0]  target_r   [PORTS];
  logic [6:0]  alias_r    [PORTS];
  logic [2:0]  mode_r     [PORTS];
  logic        out_val_r  [PORTS];
  logic        held_r     [PORTS];
  logic [15:0] count      [PORTS];
  port_flags_t flags      [PORTS];
  logic [1:0]  drive_val;
  logic [1:0]  drive_oe;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      wire wr_port = ce_i & reg_wr_i & port_we[p];

      port_error_tracker #(
        .CNT_W (16)
      ) u_tracker (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .ce_i        (ce_i),
        .events_i    (port_events_i[p]),
        .link_up_i   (link_up[p]),
        .err_reset_i (err_reset_i),
        .count_o     (count[p]),
        .flags_o     (flags[p])
      );

      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          target_r[p]  <= `RST_ADDR_FIELD;
          alias_r[p]   <= `RST_ADDR_FIELD;
          mode_r[p]    <= `RST_PIN_MODE;
          out_val_r[p] <= `RST_PIN_OUT_VALUE;
        end else if (wr_port) begin
          if (hit_tgt) begin
            target_r[p] <= reg_wdata_i[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
          end
          if (hit_als) begin
            alias_r[p] <= reg_wdata_i[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
          end
          if (hit_pin) begin
            mode_r[p]    <= reg_wdata_i[`PIN_MODE_MSB:`PIN_MODE_LSB];
            out_val_r[p] <= reg_wdata_i[`PIN_OUT_VALUE_BIT];
          end
        end
      end

      // ------------------------------------------------------------
      // Remote value alignment
      // ------------------------------------------------------------
      // Delayed two stages to line up with the synchronised link detect;
      // Without it the hold stage would capture what a dropping link carries
      logic [1:0] remote_dly_r;

      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          remote_dly_r <= 2'h0;
        end else if (ce_i) begin
          remote_dly_r <= {remote_dly_r[0], remote_pin_value_i[p]};
        end
      end

      wire remote_v = remote_dly_r[1];

      // hold remote value
      // Tracks the remote value only while the link is up, so it freezes on loss
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          held_r[p] <= 1'b0;
        end else if (ce_i && link_up[p]) begin
          held_r[p] <= remote_v;
        end
      end

      wire is_local_out  = mode_r[p] == `PIN_MODE_LOCAL_OUT;
      wire is_remote_hld = mode_r[p] == `PIN_MODE_REMOTE_HOLD;
      wire is_remote_dft = mode_r[p] == `PIN_MODE_REMOTE_DFLT;
      wire remote_dft_v  = link_up[p] ? remote_v : out_val_r[p];
      assign drive_oe[p]  = is_local_out | is_remote_hld | is_remote_dft;
      assign drive_val[p] = is_local_out  ? out_val_r[p] :
                            is_remote_hld ? held_r[p]    :
                            is_remote_dft ? remote_dft_v : 1'b0;
    end
  endgenerate

  // ------------------------------------------------------------
  // Pin drivers, registered so the pads never see decode glitches
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_zero_o                <= 1'b0;
      pin_zero_oe_o             <= 1'b0;
      second_port_pin_zero_o    <= 1'b0;
      second_port_pin_zero_oe_o <= 1'b0;
      local_pin_value_o         <= 2'h0;
    end else if (ce_i) begin
      pin_zero_o                <= drive_val[0];
      pin_zero_oe_o             <= drive_oe[0];
      second_port_pin_zero_o    <= drive_val[1];
      second_port_pin_zero_oe_o <= drive_oe[1];
      local_pin_value_o         <= pin_in;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire         rp      = sel;
  wire [15:0]  cnt_sel = count[rp];
  port_flags_t flg_sel;
  assign flg_sel = flags[rp];

  wire [7:0] status_byte = {3'h0, flg_sel.link_lost, flg_sel.selftest_err,
                            clock_present, flg_sel.normal_err, link_up[rp]};
  wire [7:0] pin_byte    = {REVISION, out_val_r[rp], mode_r[rp]};

  wire [7:0] rd_mux = hit_tgt  ? {target_r[rp], 1'b0} :
                      hit_als  ? {alias_r[rp], 1'b0}  :
                      hit_cntl ? cnt_sel[7:0]         :
                      hit_cnth ? cnt_sel[15:8]        :
                      hit_stat ? status_byte          :
                      hit_pin  ? pin_byte             : 8'h00;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `RST_RDATA;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Alias lookup for forwarded transactions
  // ------------------------------------------------------------
  // remap to target
  wire [6:0] f_alias  = alias_r[fwd_req_i.port];
  wire [6:0] f_target = target_r[fwd_req_i.port];
  wire       f_hit    = (f_alias == fwd_req_i.alias_addr) &&
                        (f_alias != 7'h00) && (f_target != 7'h00);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fwd_rsp_o <= '0;
    end else if (ce_i) begin
      fwd_rsp_o.done        <= fwd_req_i.valid;
      fwd_rsp_o.hit         <= fwd_req_i.valid & f_hit;
      fwd_rsp_o.port        <= fwd_req_i.port;
      fwd_rsp_o.target_addr <= f_hit ? f_target : 7'h00;
    end
  end

endmodule

// File: serializer_link_status_gpio_regs_properties.sv
// ----
// Port checks of the register block
// ----
module link_regs_checker (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       second_port_view_select_i,
  input wire logic       err_reset_i,
  input wire serializer_link_pkg::port_events_t [1:0] port_events_i,
  input wire logic [1:0] link_detect_i,
  input wire logic       input_clock_present_i,
  input wire serializer_link_pkg::fwd_req_t fwd_req_i,
  input wire serializer_link_pkg::fwd_rsp_t fwd_rsp_o,
  input wire logic       pin_zero_o,
  input wire logic       pin_zero_oe_o
);
  import serializer_link_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic rd_stat;
  logic pin_wr;
  assign rd_stat = ce_i && reg_rd_i && reg_addr_i == 8'h0c && !second_port_view_select_i;
  assign pin_wr = ce_i && reg_wr_i && reg_addr_i == 8'h0d && !second_port_view_select_i;
  property p_fwd_done;
    fwd_req_i.valid && ce_i |=> fwd_rsp_o.done;
  endproperty
  a_fwd_done: assert property (p_fwd_done) else $error("no forward answer");
  property p_fwd_hit;
    fwd_rsp_o.done |-> fwd_rsp_o.hit == (fwd_rsp_o.target_addr != 7'h00);
  endproperty
  a_fwd_hit: assert property (p_fwd_hit) else $error("hit and target disagree");
  property p_res_bit;
    ce_i && reg_rd_i && (reg_addr_i == 8'h07 || reg_addr_i == 8'h08) |=> !reg_rdata_o[0];
  endproperty
  a_res_bit: assert property (p_res_bit) else $error("address bit 0 not zero");
  property p_norm_err;
    ce_i && port_events_i[0].crc_err && !port_events_i[0].selftest_active
      && !second_port_view_select_i ##1 rd_stat |=> reg_rdata_o[1];
  endproperty
  a_norm_err: assert property (p_norm_err) else $error("normal error flag missing");
  property p_link_lost;
    (link_detect_i[0] && ce_i)[*3] ##1 (!link_detect_i[0] && ce_i && !err_reset_i)[*5]
      ##0 rd_stat |=> reg_rdata_o[4] && !reg_rdata_o[0];
  endproperty
  a_link_lost: assert property (p_link_lost) else $error("link loss not flagged");
  property p_clock;
    (input_clock_present_i && ce_i)[*3] ##0 rd_stat |=> reg_rdata_o[2];
  endproperty
  a_clock: assert property (p_clock) else $error("clock present not shown");
  property p_out_mode;
    pin_wr && reg_wdata_i[2:0] == 3'h1 ##1 ce_i
      |=> pin_zero_oe_o && pin_zero_o == $past(reg_wdata_i[3], 2);
  endproperty
  a_out_mode: assert property (p_out_mode) else $error("output mode not driven");
  property p_off_mode;
    pin_wr && (!reg_wdata_i[0] || reg_wdata_i[2:0] == 3'h3) ##1 ce_i |=> !pin_zero_oe_o;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("input mode drives pin");
endmodule

bind serializer_link_status_gpio_regs link_regs_checker chk (.clock_i, .reset_n_i, .ce_i,
  .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .second_port_view_select_i,
  .err_reset_i,
  .port_events_i, .link_detect_i, .input_clock_present_i, .fwd_req_i, .fwd_rsp_o,
  .pin_zero_o, .pin_zero_oe_o);

// File: remote_link_model.sv
// ----
// Far side: remote link status, pin values, error events
// ----
module remote_link_model (
  input  wire logic [1:0] link_up_i,
  input  wire logic       clock_i,
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] crc_i,
  input  wire logic       selftest_i,
  input  wire logic       restart_i,
  output logic [1:0]      link_detect_o,
  output logic [1:0]      remote_pin_value_o,
  output serializer_link_pkg::port_events_t [1:0] port_events_o
);
  import serializer_link_pkg::*;
  logic tgl = 1'b0;
  // A dead link carries noise, not the last pin value
  always @(posedge clock_i) begin
    tgl <= ~tgl;
    link_detect_o <= link_up_i;
    for (int p = 0; p < 2; p++) begin
      remote_pin_value_o[p] <= link_up_i[p] ? pin_i[p] : tgl;
      port_events_o[p] <= '{crc_i[p] & link_up_i[p], selftest_i, restart_i};
    end
  end
endmodule

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serializer_link_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} row_t;
  logic clock_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic sel = 1'b0, err_rst = 1'b0, clk_ok = 1'b0, st = 1'b0, rst_st = 1'b0, ext = 1'b1;
  logic [1:0] link_up = 2'h0, rpin = 2'h0, crc = 2'h0, ldet, rval, lpin;
  logic p0, p0_oe, p1, p1_oe;
  port_events_t [1:0] ev;
  fwd_req_t fwd_req_i = '0;
  fwd_rsp_t fwd_rsp_o;
  int mismatches = 0, checks_done = 0;
  row_t rows[9] = '{'{8'h07, 8'h00, 0, 8'h00}, '{8'h0d, 8'h00, 0, 8'h00},
    '{8'h07, 8'hff, 1, 8'hfe}, '{8'h08, 8'ha5, 1, 8'ha4}, '{8'h0a, 8'h55, 1, 8'h00},
    '{8'h0b, 8'h55, 1, 8'h00}, '{8'h0c, 8'hff, 1, 8'h00}, '{8'h0d, 8'hf0, 1, 8'h00},
    '{8'h21, 8'h33, 1, 8'h00}};
  logic [7:0] offm[5] = '{8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0e};

  remote_link_model far (.clock_i, .link_up_i(link_up), .pin_i(rpin), .crc_i(crc),
    .selftest_i(st), .restart_i(rst_st), .link_detect_o(ldet), .remote_pin_value_o(rval),
    .port_events_o(ev));
  serializer_link_status_gpio_regs uut (.clock_i, .reset_n_i, .ce_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .second_port_view_select_i(sel),
    .err_reset_i(err_rst), .port_events_i(ev), .link_detect_i(ldet),
    .input_clock_present_i(clk_ok), .remote_pin_value_i(rval), .fwd_req_i, .fwd_rsp_o,
    .pin_zero_in_i(p0_oe ? p0 : ext), .pin_zero_o(p0), .pin_zero_oe_o(p0_oe),
    .second_port_pin_zero_in_i(p1_oe ? p1 : ext), .second_port_pin_zero_o(p1),
    .second_port_pin_zero_oe_o(p1_oe), .local_pin_value_o(lpin));

  always #20 clock_i = ~clock_i;

  // ----
  // Bus cycles and comparison
  // ----
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, e);
  endtask
  task automatic fwd(input logic p, input logic [6:0] a, input logic [7:0] e);
    @(posedge clock_i);
    fwd_req_i <= '{1'b1, p, a};
    @(posedge clock_i);
    fwd_req_i.valid <= 1'b0;
    #1 check({fwd_rsp_o.hit, fwd_rsp_o.target_addr}, e);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    #(3000 * 40);
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    $display("register table done");
    fwd(1'b0, 7'h52, 8'hff);
    fwd(1'b0, 7'h53, 8'h00);
    fwd(1'b1, 7'h52, 8'h00);
    wr(8'h07, 8'h00);
    fwd(1'b0, 7'h52, 8'h00);
    $display("forwarding done");
    @(posedge clock_i) link_up <= 2'h3;
    clk_ok <= 1'b1;
    tick(6);
    repeat (3) begin
      @(posedge clock_i) crc <= 2'h1;
      @(posedge clock_i) crc <= 2'h0;
    end
    rdchk(8'h0c, 8'h07);
    rdchk(8'h0a, 8'h03);
    rdchk(8'h0b, 8'h00);
    @(posedge clock_i) {st, crc} <= 3'h5;
    @(posedge clock_i) {st, crc} <= 3'h0;
    rdchk(8'h0c, 8'h0f);
    rdchk(8'h0a, 8'h04);
    @(posedge clock_i) rst_st <= 1'b1;
    @(posedge clock_i) rst_st <= 1'b0;
    rdchk(8'h0c, 8'h07);
    @(posedge clock_i) sel <= 1'b1;
    rdchk(8'h0a, 8'h00);
    @(posedge clock_i) crc <= 2'h2;
    @(posedge clock_i) crc <= 2'h0;
    rdchk(8'h0a, 8'h01);
    rdchk(8'h0c, 8'h07);
    @(posedge clock_i) sel <= 1'b0;
    @(posedge clock_i) err_rst <= 1'b1;
    @(posedge clock_i) err_rst <= 1'b0;
    rdchk(8'h0a, 8'h00);
    rdchk(8'h0c, 8'h05);
    @(posedge clock_i) link_up <= 2'h2;
    tick(4);
    rdchk(8'h0c, 8'h14);
    @(posedge clock_i) link_up <= 2'h3;
    tick(4);
    rdchk(8'h0c, 8'h15);
    @(posedge clock_i) err_rst <= 1'b1;
    @(posedge clock_i) err_rst <= 1'b0;
    rdchk(8'h0c, 8'h05);
    $display("error tracking done");
    wr(8'h0d, 8'h09);
    tick(2);
    check({6'h00, p0_oe, p0}, 8'h03);
    // Pins float low from here, so a pin still driven high would show
    @(posedge clock_i) ext <= 1'b0;
    foreach (offm[i]) begin
      wr(8'h0d, offm[i]);
      tick(4);
      check({5'h00, lpin, p0_oe}, 8'h00);
    end
    @(posedge clock_i) rpin <= 2'h3;
    wr(8'h0d, 8'h05);
    tick(4);
    check({6'h00, p0_oe, p0}, 8'h03);
    @(posedge clock_i) link_up <= 2'h2;
    tick(5);
    check({6'h00, p0_oe, p0}, 8'h03);
    tick(3);
    check({6'h00, p0_oe, p0}, 8'h03);
    wr(8'h0d, 8'h07);
    tick(2);
    check({6'h00, p0_oe, p0}, 8'h02);
    @(posedge clock_i) link_up <= 2'h3;
    tick(6);
    check({6'h00, p0_oe, p0}, 8'h03);
    @(posedge clock_i) sel <= 1'b1;
    wr(8'h0d, 8'h09);
    tick(2);
    check({6'h00, p1_oe, p1}, 8'h03);
    check({6'h00, p0_oe, p0}, 8'h03);
    $display("pin modes done");
    @(posedge clock_i) reset_n_i <= 1'b0;
    tick(2);
    check({5'h00, p1_oe, p0_oe, p0}, 8'h00);
    check(reg_rdata_o, 8'h00);
    @(posedge clock_i) reset_n_i <= 1'b1;
    rdchk(8'h0a, 8'h00);
    rdchk(8'h0d, 8'h00);
    @(posedge clock_i) ce_i <= 1'b0;
    wr(8'h07, 8'h22);
    @(posedge clock_i) ce_i <= 1'b1;
    rdchk(8'h07, 8'h00);
    $display("reset and clock enable done");
    complete_run;
  end
endmodule
